// ---- hdl/mie_exec_unit.sv ----
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// RULE_01: Set-memory writes FFH to the byte; flags unchanged.
// RULE_02: Set-bit forces one selected bit to one; others and flags kept.
// RULE_03: Increment-skip writes byte plus one back; skips when sum is zero.
// RULE_04: Increment-skip-to-wreg puts byte plus one in wreg; memory untouched; skip on zero.
// RULE_05: A taken skip adds one dummy cycle, so the instruction takes two cycles; here a skipped one takes four cycles and an unskipped one three.
// RULE_06: Bit-nonzero-skip skips when the selected bit is one; flags kept.
// RULE_07: Byte-nonzero-skip skips when the byte is nonzero.
// RULE_08: Byte-test skips read the byte and write the same value back.
// RULE_09: Byte-zero-skip skips when the byte is zero.
// RULE_10: Zero-skip-with-move copies byte into wreg; skips on zero; flags kept.
// RULE_11: Bit-zero-skip skips when the selected bit is zero.
// RULE_12: Subtract-memory puts wreg minus byte in wreg; updates six flags.
// RULE_13: Carry clears on negative difference, sets on zero or positive.
// RULE_14: Subtract-to-memory writes wreg minus byte to the byte; six flags updated.
// RULE_15: Subtract-immediate puts wreg minus immediate in wreg; six flags updated.
// RULE_16: Nibble exchange swaps byte nibbles in place; flags kept.
// RULE_17: Nibble-exchange-to-wreg puts swapped byte in wreg; memory untouched.
// RULE_18: Specific-page table read uses both pointer bytes; low to memory, high to latch.
// RULE_19: Last-page table read uses last page and low pointer byte.
// RULE_20: Incrementing specific-page read bumps low pointer first, then reads.
// RULE_21: Incrementing last-page read bumps low pointer first; table reads keep flags.
// RULE_22: Exclusive-OR into wreg with memory or immediate; memory form updates zero only.
// RULE_23: Exclusive-OR-to-memory writes result to the byte and updates zero.
// RULE_24: A taken skip squashes the fetched next instruction, then fetch resumes.
module mie_exec_unit
  import mie_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // Instruction issue port
  input wire logic I_INSTR_VALID,
  input wire logic [4:0] I_INSTR_OP,
  input wire logic [7:0] I_INSTR_ADDR,
  input wire logic [2:0] I_INSTR_BIT,
  input wire logic [7:0] I_INSTR_IMM,
  output logic O_INSTR_READY,
  output logic O_SKIP_SQUASH,
  // Data memory port
  output logic O_DMEM_RD,
  output logic O_DMEM_WR,
  output logic [7:0] O_DMEM_ADDR,
  output logic [7:0] O_DMEM_WDATA,
  input wire logic [7:0] I_DMEM_RDATA,
  // Program memory port
  output logic O_PMEM_RD,
  output logic [15:0] O_PMEM_ADDR,
  input wire logic [15:0] I_PMEM_RDATA,
  // Avalon-MM register slave
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);

  typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_EXEC, ST_DUMMY} mie_state_t;

  mie_state_t state_r, state_nxt;
  logic [4:0] op_r;
  logic [7:0] addr_r;
  logic [2:0] bit_r;
  logic [7:0] imm_r;
  logic [7:0] wreg_r;
  logic [5:0] flags_r;
  logic [7:0] tbl_low_r;
  logic [7:0] tbl_high_r;
  logic [7:0] tbl_latch_r;
  logic last_skip_r;
  logic dmem_wr_r;
  logic [7:0] dmem_wdata_r;
  logic bus_ack_r;
  logic [31:0] readdata_r;

  // Decode of the latched operation
  wire is_table = (op_r == OP_TRD_SPEC) || (op_r == OP_TRD_LAST) ||
                  (op_r == OP_ITRD_SPEC) || (op_r == OP_ITRD_LAST);
  wire is_last_page = (op_r == OP_TRD_LAST) || (op_r == OP_ITRD_LAST);
  wire is_imm = (op_r == OP_SUB_IMM) || (op_r == OP_XOR_IMM);
  wire needs_dmem = !is_table && !is_imm && (op_r != OP_SET_M);
  wire in_exec = (state_r == ST_EXEC);
  wire in_idle = (state_r == ST_IDLE);

  // Bus access holds the issue port off so both never touch state together
  wire bus_req = I_AVS_READ || I_AVS_WRITE;
  wire bus_take = bus_req && in_idle && !bus_ack_r;
  wire bus_wr = bus_ack_r && I_AVS_WRITE;
  wire issue = I_INSTR_VALID && O_INSTR_READY;
  wire issue_incr = issue && ((I_INSTR_OP == OP_ITRD_SPEC) || (I_INSTR_OP == OP_ITRD_LAST));

  // Operand selection and arithmetic
  wire [7:0] operand = is_imm ? imm_r : I_DMEM_RDATA;
  wire [8:0] diff = {1'b0, wreg_r} - {1'b0, operand};
  wire [7:0] sub_res = diff[7:0];
  wire [4:0] nib_diff = {1'b0, wreg_r[3:0]} - {1'b0, operand[3:0]};
  wire sub_c = !diff[8];
  wire sub_ov = (wreg_r[7] ^ operand[7]) && (wreg_r[7] ^ sub_res[7]);
  wire sub_z = (sub_res == ZERO_BYTE);
  wire [7:0] inc_res = I_DMEM_RDATA + ONE_BYTE;
  wire [7:0] xor_res = wreg_r ^ operand;
  wire [7:0] swap_res = {I_DMEM_RDATA[3:0], I_DMEM_RDATA[7:4]};
  wire [7:0] bit_mask = ONE_BYTE << bit_r;
  wire sel_bit = |(I_DMEM_RDATA & bit_mask);
  wire [5:0] sub_flags = {sub_z, sub_ov ^ sub_res[7], sub_ov, sub_z, !nib_diff[4], sub_c};

  // Handshake outputs
  assign O_INSTR_READY = in_idle && !bus_req;
  assign O_SKIP_SQUASH = (state_r == ST_DUMMY); // RULE_24
  assign O_DMEM_RD = (state_r == ST_OPND) && needs_dmem;
  assign O_PMEM_RD = (state_r == ST_OPND) && is_table;
  assign O_PMEM_ADDR = {is_last_page ? LAST_PAGE : tbl_high_r, tbl_low_r}; // RULE_18 RULE_19
  assign O_DMEM_ADDR = addr_r;
  assign O_DMEM_WR = dmem_wr_r;
  assign O_DMEM_WDATA = dmem_wdata_r;
  assign O_AVS_WAITREQUEST = bus_req && !bus_ack_r;
  assign O_AVS_READDATA = readdata_r;

  // Execution results of the current operation
  logic mem_we;
  logic [7:0] mem_wd;
  logic wreg_we;
  logic [7:0] wreg_wd;
  logic flags_we;
  logic [5:0] flags_wd;
  logic latch_we;
  logic skip;
  always_comb begin
    mem_we = 1'b0;
    mem_wd = I_DMEM_RDATA;
    wreg_we = 1'b0;
    wreg_wd = wreg_r;
    flags_we = 1'b0;
    flags_wd = flags_r;
    latch_we = 1'b0;
    skip = 1'b0;
    case (op_r)
      OP_SET_M: begin
        mem_we = 1'b1;
        mem_wd = ALL_ONES; // RULE_01
      end
      OP_SET_BIT: begin
        mem_we = 1'b1;
        mem_wd = I_DMEM_RDATA | bit_mask; // RULE_02
      end
      OP_INC_SKIP_ZERO: begin
        mem_we = 1'b1;
        mem_wd = inc_res; // RULE_03
        skip = (inc_res == ZERO_BYTE);
      end
      OP_INC_SKIP_ZERO_W: begin
        wreg_we = 1'b1;
        wreg_wd = inc_res; // RULE_04
        skip = (inc_res == ZERO_BYTE);
      end
      OP_SKIP_NZ_BIT: begin
        skip = sel_bit; // RULE_06
      end
      OP_SKIP_NZ: begin
        mem_we = 1'b1; // RULE_08
        skip = (I_DMEM_RDATA != ZERO_BYTE); // RULE_07
      end
      OP_SKIP_Z: begin
        mem_we = 1'b1; // RULE_08
        skip = (I_DMEM_RDATA == ZERO_BYTE); // RULE_09
      end
      OP_SKIP_Z_MOVE_W: begin
        wreg_we = 1'b1;
        wreg_wd = I_DMEM_RDATA; // RULE_10
        skip = (I_DMEM_RDATA == ZERO_BYTE);
      end
      OP_SKIP_Z_BIT: begin
        skip = !sel_bit; // RULE_11
      end
      OP_SUB_M, OP_SUB_IMM: begin
        wreg_we = 1'b1;
        wreg_wd = sub_res; // RULE_12 RULE_15
        flags_we = 1'b1;
        flags_wd = sub_flags; // RULE_13
      end
      OP_SUB_TO_M: begin
        mem_we = 1'b1;
        mem_wd = sub_res; // RULE_14
        flags_we = 1'b1;
        flags_wd = sub_flags;
      end
      OP_SWAP_M: begin
        mem_we = 1'b1;
        mem_wd = swap_res; // RULE_16
      end
      OP_SWAP_W: begin
        wreg_we = 1'b1;
        wreg_wd = swap_res; // RULE_17
      end
      OP_TRD_SPEC, OP_TRD_LAST, OP_ITRD_SPEC, OP_ITRD_LAST: begin
        mem_we = 1'b1;
        mem_wd = I_PMEM_RDATA[7:0]; // RULE_18 RULE_19
        latch_we = 1'b1;
      end
      OP_XOR_M, OP_XOR_IMM: begin
        wreg_we = 1'b1;
        wreg_wd = xor_res; // RULE_22
        flags_we = 1'b1;
        flags_wd[FLAG_Z] = (xor_res == ZERO_BYTE);
      end
      OP_XOR_TO_M: begin
        mem_we = 1'b1;
        mem_wd = xor_res; // RULE_23
        flags_we = 1'b1;
        flags_wd[FLAG_Z] = (xor_res == ZERO_BYTE);
      end
      default: begin
        skip = 1'b0;
      end
    endcase
  end

  // Sequencer: operand fetch, execute, optional dummy cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (issue) state_nxt = ST_OPND;
      ST_OPND: state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = skip ? ST_DUMMY : ST_IDLE; // RULE_05
      ST_DUMMY: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // Latch the issued instruction fields
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      op_r <= OP_SET_M;
      addr_r <= ZERO_BYTE;
      bit_r <= 3'h0;
      imm_r <= ZERO_BYTE;
    end else if (issue) begin
      op_r <= I_INSTR_OP;
      addr_r <= I_INSTR_ADDR;
      bit_r <= I_INSTR_BIT;
      imm_r <= I_INSTR_IMM;
    end
  end

  // Registered data memory write, one cycle after execute
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      dmem_wr_r <= 1'b0;
      dmem_wdata_r <= ZERO_BYTE;
    end else begin
      dmem_wr_r <= in_exec && mem_we;
      if (in_exec && mem_we) dmem_wdata_r <= mem_wd;
    end
  end

  // Working register and flags, from execute or from the bus
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      wreg_r <= WREG_RST;
      flags_r <= FLAGS_RST;
      last_skip_r <= 1'b0;
    end else begin
      if (in_exec && wreg_we) wreg_r <= wreg_wd;
      else if (bus_wr && I_AVS_ADDRESS == REG_WREG) wreg_r <= I_AVS_WRITEDATA[7:0];
      if (in_exec && flags_we) flags_r <= flags_wd;
      else if (bus_wr && I_AVS_ADDRESS == REG_FLAGS) flags_r <= I_AVS_WRITEDATA[5:0];
      if (in_exec) last_skip_r <= skip;
    end
  end

  // Table pointer and table-high latch
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      tbl_low_r <= TBL_PTR_RST;
      tbl_high_r <= TBL_PTR_RST;
      tbl_latch_r <= ZERO_BYTE;
    end else begin
      if (issue_incr) tbl_low_r <= tbl_low_r + ONE_BYTE; // RULE_20 RULE_21
      else if (bus_wr && I_AVS_ADDRESS == REG_TBL_LOW) tbl_low_r <= I_AVS_WRITEDATA[7:0];
      if (bus_wr && I_AVS_ADDRESS == REG_TBL_HIGH) tbl_high_r <= I_AVS_WRITEDATA[7:0];
      if (in_exec && latch_we) tbl_latch_r <= I_PMEM_RDATA[15:8]; // RULE_18
    end
  end

  // Avalon read mux, unmapped offsets read zero
  logic [31:0] read_mux;
  always_comb begin
    case (I_AVS_ADDRESS)
      REG_WREG: read_mux = {24'h000000, wreg_r};
      REG_FLAGS: read_mux = {26'h0000000, flags_r};
      REG_TBL_LOW: read_mux = {24'h000000, tbl_low_r};
      REG_TBL_HIGH: read_mux = {24'h000000, tbl_high_r};
      REG_TBL_LATCH: read_mux = {24'h000000, tbl_latch_r};
      REG_STATUS: read_mux = {31'h00000000, last_skip_r};
      default: read_mux = 32'h00000000;
    endcase
  end

  // One wait cycle per bus access made while the sequencer is idle
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      bus_ack_r <= 1'b0;
      readdata_r <= 32'h00000000;
    end else begin
      bus_ack_r <= bus_take;
      if (bus_take) readdata_r <= read_mux;
    end
  end

  // Checks
  sequence s_exec(logic [4:0] op);
    in_exec && op_r == op;
  endsequence

  sequence s_skip_tail;
    O_SKIP_SQUASH ##1 (O_INSTR_READY || bus_req) && !O_SKIP_SQUASH;
  endsequence

  property p_set_ones;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    s_exec(OP_SET_M) |=> O_DMEM_WR && O_DMEM_WDATA == ALL_ONES && $stable(flags_r);
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("set-memory wrong"); // RULE_01

  property p_set_bit;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    s_exec(OP_SET_BIT) |=> O_DMEM_WR &&
      O_DMEM_WDATA == ($past(I_DMEM_RDATA) | (ONE_BYTE << $past(bit_r)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set-bit wrong"); // RULE_02

  property p_inc_skip;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    s_exec(OP_INC_SKIP_ZERO) ##0 (I_DMEM_RDATA == ALL_ONES) |=>
      (O_DMEM_WR && O_DMEM_WDATA == ZERO_BYTE) and s_skip_tail;
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("increment-skip wrong"); // RULE_03

  property p_skip_two_cycles;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    in_exec && skip |=> s_skip_tail;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("no dummy"); // RULE_05

  property p_no_skip;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    in_exec && !skip |=> !O_SKIP_SQUASH;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("spurious squash"); // RULE_24

  property p_sub_carry;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    in_exec && (op_r == OP_SUB_M || op_r == OP_SUB_IMM) |=>
      flags_r[FLAG_C] == ($past(wreg_r) >= $past(operand)) &&
      wreg_r == $past(wreg_r) - $past(operand);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong"); // RULE_13

  property p_swap_w;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    s_exec(OP_SWAP_W) |=> wreg_r == {$past(I_DMEM_RDATA[3:0]), $past(I_DMEM_RDATA[7:4])} &&
      !O_DMEM_WR;
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap to wreg wrong"); // RULE_17

  property p_incr_ptr;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    issue_incr |=> tbl_low_r == $past(tbl_low_r) + ONE_BYTE && O_PMEM_RD &&
      O_PMEM_ADDR[7:0] == $past(tbl_low_r) + ONE_BYTE;
  endproperty
  a_incr_ptr: assert property (p_incr_ptr) else $error("pointer not bumped"); // RULE_20

  property p_table_latch;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    in_exec && is_table |=> tbl_latch_r == $past(I_PMEM_RDATA[15:8]) &&
      O_DMEM_WDATA == $past(I_PMEM_RDATA[7:0]) && $stable(flags_r);
  endproperty
  a_table_latch: assert property (p_table_latch) else $error("table read wrong"); // RULE_18

  property p_xor_zero;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
    s_exec(OP_XOR_M) |=> flags_r[FLAG_Z] == (wreg_r == ZERO_BYTE) &&
      flags_r[FLAG_C] == $past(flags_r[FLAG_C]);
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong"); // RULE_22

endmodule : mie_exec_unit

// ---- pkg/mie_pkg.sv ----
package mie_pkg;

  // Operation codes presented on the issue port
  localparam logic [4:0] OP_SET_M = 5'h00;
  localparam logic [4:0] OP_SET_BIT = 5'h01;
  localparam logic [4:0] OP_INC_SKIP_ZERO = 5'h02;
  localparam logic [4:0] OP_INC_SKIP_ZERO_W = 5'h03;
  localparam logic [4:0] OP_SKIP_NZ_BIT = 5'h04;
  localparam logic [4:0] OP_SKIP_NZ = 5'h05;
  localparam logic [4:0] OP_SUB_M = 5'h06;
  localparam logic [4:0] OP_SUB_TO_M = 5'h07;
  localparam logic [4:0] OP_SUB_IMM = 5'h08;
  localparam logic [4:0] OP_SWAP_M = 5'h09;
  localparam logic [4:0] OP_SWAP_W = 5'h0A;
  localparam logic [4:0] OP_SKIP_Z = 5'h0B;
  localparam logic [4:0] OP_SKIP_Z_MOVE_W = 5'h0C;
  localparam logic [4:0] OP_SKIP_Z_BIT = 5'h0D;
  localparam logic [4:0] OP_TRD_SPEC = 5'h0E;
  localparam logic [4:0] OP_TRD_LAST = 5'h0F;
  localparam logic [4:0] OP_ITRD_SPEC = 5'h10;
  localparam logic [4:0] OP_ITRD_LAST = 5'h11;
  localparam logic [4:0] OP_XOR_M = 5'h12;
  localparam logic [4:0] OP_XOR_TO_M = 5'h13;
  localparam logic [4:0] OP_XOR_IMM = 5'h14;

  // Flag bit positions in the flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] REG_WREG = 5'h00;
  localparam logic [4:0] REG_FLAGS = 5'h04;
  localparam logic [4:0] REG_TBL_LOW = 5'h08;
  localparam logic [4:0] REG_TBL_HIGH = 5'h0C;
  localparam logic [4:0] REG_TBL_LATCH = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;

  // Reset values and fixed constants
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] TBL_PTR_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] LAST_PAGE = 8'hFF;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage : mie_pkg

// ---- tb/mie_mem_model.sv ----
`timescale 1ns/1ps
// Data memory and program memory seen by the execute unit
module mie_mem_model
  import mie_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Data memory side
  input wire logic i_dmem_rd,
  input wire logic i_dmem_wr,
  input wire logic [7:0] i_dmem_addr,
  input wire logic [7:0] i_dmem_wdata,
  output logic [7:0] o_dmem_rdata = 8'h00,
  // Program memory side
  input wire logic i_pmem_rd,
  input wire logic [15:0] i_pmem_addr,
  output logic [15:0] o_pmem_rdata = 16'h0000
);
  logic [7:0] mem [256];

  // Data answers the cycle after a strobe; otherwise the lines toggle
  always @(posedge i_clk) begin
    o_dmem_rdata <= i_dmem_rd ? mem[i_dmem_addr] : ~o_dmem_rdata;
    o_pmem_rdata <= i_pmem_rd ? {i_pmem_addr[7:0], i_pmem_addr[15:8]} ^ 16'hA55A : ~o_pmem_rdata;
    if (i_dmem_wr) begin
      mem[i_dmem_addr] <= i_dmem_wdata;
    end
  end
endmodule : mie_mem_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
  import mie_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0;
  logic [4:0] iop = 5'h00;
  logic [7:0] ia = 8'h00;
  logic [2:0] ib = 3'h0;
  logic [7:0] ix = 8'h00;
  logic rdy, sq, drd, dwr, prd, awt;
  logic [7:0] dad, dwd, drdt;
  logic [15:0] pad, prdt;
  logic [4:0] aad = 5'h00;
  logic ard = 1'b0;
  logic awr = 1'b0;
  logic [31:0] awd = 32'h0;
  logic [31:0] ardt;
  logic [15:0] wq[$];
  logic [31:0] rq[$];
  logic [7:0] w = 8'h00;
  logic [7:0] tlo = 8'h00;
  logic [7:0] thi = 8'h00;
  logic [7:0] lat = 8'h00;
  logic [5:0] f = 6'h00;
  int failures = 0;
  int samples_checked = 0;

  // Core clock, 5 ns period
  always #2.5 clk = ~clk;

  mie_exec_unit uut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_INSTR_VALID(iv), .I_INSTR_OP(iop),
    .I_INSTR_ADDR(ia), .I_INSTR_BIT(ib), .I_INSTR_IMM(ix), .O_INSTR_READY(rdy),
    .O_SKIP_SQUASH(sq), .O_DMEM_RD(drd), .O_DMEM_WR(dwr), .O_DMEM_ADDR(dad),
    .O_DMEM_WDATA(dwd), .I_DMEM_RDATA(drdt), .O_PMEM_RD(prd), .O_PMEM_ADDR(pad),
    .I_PMEM_RDATA(prdt), .I_AVS_ADDRESS(aad), .I_AVS_READ(ard), .I_AVS_WRITE(awr),
    .I_AVS_WRITEDATA(awd), .O_AVS_READDATA(ardt), .O_AVS_WAITREQUEST(awt)
  );

  mie_mem_model mdl (
    .i_clk(clk), .i_dmem_rd(drd), .i_dmem_wr(dwr), .i_dmem_addr(dad),
    .i_dmem_wdata(dwd), .o_dmem_rdata(drdt), .i_pmem_rd(prd), .i_pmem_addr(pad),
    .o_pmem_rdata(prdt)
  );

  // Prints the counts and the verdict, then ends the run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // One comparison
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask : chk

  // Bus cycle held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    int k;
    @(posedge clk);
    awr <= wr;
    ard <= !wr;
    aad <= a;
    awd <= d;
    if (!wr) begin
      rq.push_back(e);
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (awt && k < 50);
    if (awt) begin
      failures++;
      finish_test();
    end
    awr <= 1'b0;
    ard <= 1'b0;
  endtask : bus

  // Issue one instruction, then time it and watch for a squash
  task automatic ex(input logic [4:0] op, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] x, input logic s);
    int k;
    logic seen;
    @(posedge clk);
    iv <= 1'b1;
    iop <= op;
    ia <= a;
    ib <= b;
    ix <= x;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!rdy && k < 50);
    iv <= 1'b0;
    k = 0;
    seen = 1'b0;
    do begin
      @(posedge clk);
      k++;
      seen = seen | sq;
    end while (!rdy && k < 50);
    if (!rdy) begin
      failures++;
      finish_test();
    end
    chk({31'h0, s}, {31'h0, seen});
    chk(s ? 32'd4 : 32'd3, k);
  endtask : ex

  // Reference subtraction: {CZ, SC, OV, Z, AC, C, difference}
  function automatic logic [13:0] sub8(input logic [7:0] p, input logic [7:0] q);
    logic [7:0] r;
    logic ov;
    r = p - q;
    ov = (p[7] ^ q[7]) & (p[7] ^ r[7]);
    return {r == 8'h00, ov ^ r[7], ov, r == 8'h00, p[3:0] >= q[3:0], p >= q, r};
  endfunction : sub8

  // Each memory write and bus read is matched to the oldest note
  always @(posedge clk) begin
    if (dwr) begin
      chk(wq.size() > 0 ? {16'h0, wq.pop_front()} : 32'hFFFFFFFF, {16'h0, dad, dwd});
    end
    if (ard && !awt) begin
      chk(rq.size() > 0 ? rq.pop_front() : 32'hFFFFFFFF, ardt);
    end
  end

  // Main sequence
  initial begin
    logic [7:0] a, m, nm, x;
    logic [2:0] b;
    logic [15:0] pw;
    logic [31:0] d;
    logic s, wm;
    void'($urandom(93));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0, 32'h0);
    end
    bus(1'b1, 5'h18, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, 5'h18, 32'h0, 32'h0);
    bus(1'b1, REG_TBL_LATCH, 32'h000000A5, 32'h0);
    bus(1'b0, REG_TBL_LATCH, 32'h0, 32'h0);
    for (int op = 0; op < 21; op++) begin
      for (int k = 0; k < 6; k++) begin
        a = 8'($urandom);
        b = 3'($urandom);
        x = 8'($urandom);
        m = (k == 0) ? ZERO_BYTE : (k == 1) ? ALL_ONES : 8'($urandom);
        d = $urandom;
        w = (k == 2) ? m : d[7:0];
        bus(1'b1, REG_WREG, {d[31:8], w}, 32'h0);
        d = $urandom;
        f = d[5:0];
        bus(1'b1, REG_FLAGS, d, 32'h0);
        d = $urandom;
        tlo = (k == 3) ? ALL_ONES : d[7:0];
        bus(1'b1, REG_TBL_LOW, {d[31:8], tlo}, 32'h0);
        d = $urandom;
        thi = d[7:0];
        bus(1'b1, REG_TBL_HIGH, d, 32'h0);
        mdl.mem[a] = m;
        nm = m;
        if (op == OP_ITRD_SPEC || op == OP_ITRD_LAST) tlo = tlo + ONE_BYTE;
        pw = {tlo, (op == OP_TRD_LAST || op == OP_ITRD_LAST) ? LAST_PAGE : thi} ^ 16'hA55A;
        case (5'(op))
          OP_SET_M: nm = ALL_ONES;
          OP_SET_BIT: nm = m | (ONE_BYTE << b);
          OP_INC_SKIP_ZERO: nm = m + ONE_BYTE;
          OP_INC_SKIP_ZERO_W: w = m + ONE_BYTE;
          OP_SUB_M: {f, w} = sub8(w, m);
          OP_SUB_IMM: {f, w} = sub8(w, x);
          OP_SUB_TO_M: {f, nm} = sub8(w, m);
          OP_SWAP_M: nm = {m[3:0], m[7:4]};
          OP_SWAP_W: w = {m[3:0], m[7:4]};
          OP_SKIP_Z_MOVE_W: w = m;
          OP_XOR_M: w = w ^ m;
          OP_XOR_IMM: w = w ^ x;
          OP_XOR_TO_M: nm = w ^ m;
          OP_TRD_SPEC, OP_TRD_LAST, OP_ITRD_SPEC, OP_ITRD_LAST: {lat, nm} = pw;
          default: ;
        endcase
        if (op >= OP_XOR_M) f[FLAG_Z] = ((op == OP_XOR_TO_M ? nm : w) == ZERO_BYTE);
        s = (op == OP_INC_SKIP_ZERO && nm == ZERO_BYTE) || (op == OP_INC_SKIP_ZERO_W && w == 8'h00)
          || (op == OP_SKIP_NZ_BIT && m[b]) || (op == OP_SKIP_NZ && m != ZERO_BYTE)
          || (op == OP_SKIP_Z_BIT && !m[b])
          || ((op == OP_SKIP_Z || op == OP_SKIP_Z_MOVE_W) && m == ZERO_BYTE);
        wm = 5'(op) inside {OP_SET_M, OP_SET_BIT, OP_INC_SKIP_ZERO, OP_SKIP_NZ, OP_SUB_TO_M,
          OP_SWAP_M, OP_SKIP_Z, OP_TRD_SPEC, OP_TRD_LAST, OP_ITRD_SPEC, OP_ITRD_LAST, OP_XOR_TO_M};
        if (wm) wq.push_back({a, nm});
        ex(5'(op), a, b, x, s);
        bus(1'b0, REG_WREG, 32'h0, {24'h0, w});
        bus(1'b0, REG_FLAGS, 32'h0, {26'h0, f});
        bus(1'b0, REG_TBL_LOW, 32'h0, {24'h0, tlo});
        bus(1'b0, REG_TBL_LATCH, 32'h0, {24'h0, lat});
        bus(1'b0, REG_STATUS, 32'h0, {31'h0, s});
      end
    end
    repeat (4) @(posedge clk);
    chk(32'h0, wq.size() + rq.size());
    finish_test();
  end
endmodule : tb
